// >>> logic/pmx_defines.vh
// constants for the processor pad multiplexer
`ifndef PMX_DEFINES_VH
`define PMX_DEFINES_VH

// pad and peripheral counts
`define PMX_NPAD       16
`define PMX_NPER       4
`define PMX_PSIG       2
`define PMX_NPSIG      8
`define PMX_IDX_W      3

// pad set placement: set 0 starts at 2*p, set 1 starts at 2*p+2 (wraps)
`define PMX_SET0_STEP  2
`define PMX_SET1_OFS   2

// pad owner codes
`define PMX_OWN_NONE   2'h0
`define PMX_OWN_PER    2'h1
`define PMX_OWN_GPIO   2'h2
`define PMX_OWN_LOAN   2'h3

// claim counter
`define PMX_CNT_ONE    2'h1
`define PMX_CNT_MANY   2'h2

// synchroniser depth
`define PMX_SYNC_W     3

`endif

// >>> logic/pmx_pad_sync.v
// three-stage pad input synchroniser with agreement filter
`timescale 1ns/100ps
module pmx_pad_sync #(
   parameter W = 16
) (
   // clock and reset
   input  wire         i_sys_clk,
   input  wire         i_reset_n,
   // raw and filtered levels
   input  wire [W-1:0] i_raw,
   output reg  [W-1:0] o_level
);

   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   genvar b;
   generate
      for (b = 0; b < W; b = b + 1) begin : g_bit
         // level moves only once stages two and three agree
         always @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               s1_reg[b]  <= 1'b0;
               s2_reg[b]  <= 1'b0;
               s3_reg[b]  <= 1'b0;
               o_level[b] <= 1'b0;
            end else begin
               s1_reg[b] <= i_raw[b];
               s2_reg[b] <= s1_reg[b];
               s3_reg[b] <= s2_reg[b];
               if (s2_reg[b] == s3_reg[b]) begin
                  o_level[b] <= s3_reg[b];
               end
            end
         end
      end
   endgenerate

endmodule // pmx_pad_sync

// >>> logic/pmx_pad_mux.v
// processor pad multiplexer with fabric-borrowed pads
`timescale 1ns/100ps
`include "pmx_defines.vh"
module pmx_pad_mux (
   // clock and reset
   input  wire                   i_sys_clk,
   input  wire                   i_reset_n,
   // boot-time configuration, captured on load
   input  wire                   i_cfg_load,
   input  wire [`PMX_NPER-1:0]   i_cfg_per_enable,
   input  wire [`PMX_NPER-1:0]   i_cfg_per_set,
   input  wire [`PMX_NPER-1:0]   i_cfg_per_to_fabric,
   input  wire [`PMX_NPAD-1:0]   i_cfg_gpio_pads,
   input  wire [`PMX_NPAD-1:0]   i_cfg_loan_pads,
   input  wire                   i_cfg_loan_permit,
   // peripheral side, two signals per instance
   input  wire [`PMX_NPSIG-1:0]  i_per_out,
   input  wire [`PMX_NPSIG-1:0]  i_per_oe,
   output reg  [`PMX_NPSIG-1:0]  o_per_in,
   // general-purpose I/O side
   input  wire [`PMX_NPAD-1:0]   i_gpio_out,
   input  wire [`PMX_NPAD-1:0]   i_gpio_oe,
   output reg  [`PMX_NPAD-1:0]   o_gpio_in,
   // fabric-borrowed pads
   input  wire [`PMX_NPAD-1:0]   i_borrowed_pad_drive_value,
   input  wire [`PMX_NPAD-1:0]   i_borrowed_pad_drive_enable,
   output wire [`PMX_NPAD-1:0]   o_borrowed_pad_sample_to_fabric,
   // peripherals routed into fabric
   output reg  [`PMX_NPSIG-1:0]  o_fab_per_out,
   output reg  [`PMX_NPSIG-1:0]  o_fab_per_oe,
   input  wire [`PMX_NPSIG-1:0]  i_fab_per_in,
   // pads
   input  wire [`PMX_NPAD-1:0]   i_pad_in,
   output wire [`PMX_NPAD-1:0]   o_pad_out,
   output wire [`PMX_NPAD-1:0]   o_pad_oe_n,
   // status
   output wire [`PMX_NPAD-1:0]   o_conflict,
   output reg                    o_conflict_any,
   output reg                    o_cfg_valid
);

   // captured configuration
   reg [`PMX_NPER-1:0]  per_en_reg;
   reg [`PMX_NPER-1:0]  per_set_reg;
   reg [`PMX_NPER-1:0]  per_fab_reg;
   reg [`PMX_NPAD-1:0]  gpio_en_reg;
   reg [`PMX_NPAD-1:0]  loan_en_reg;
   reg                  permit_reg;
   wire [`PMX_NPAD-1:0] pad_sync;
   wire [`PMX_NPAD-1:0] conflict_next;

   // pad number of peripheral p, signal s
   function integer pad_of;
      input integer p;
      input integer s;
      input         set;
      integer       base;
      begin
         base = p * `PMX_SET0_STEP;
         if (set) begin
            base = base + `PMX_SET1_OFS;
         end
         pad_of = (base + s) % `PMX_NPAD;
      end
   endfunction

   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         per_en_reg  <= {`PMX_NPER{1'b0}};
         per_set_reg <= {`PMX_NPER{1'b0}};
         per_fab_reg <= {`PMX_NPER{1'b0}};
         gpio_en_reg <= {`PMX_NPAD{1'b0}};
         loan_en_reg <= {`PMX_NPAD{1'b0}};
         permit_reg  <= 1'b0;
         o_cfg_valid <= 1'b0;
      end else if (i_cfg_load) begin
         per_en_reg  <= i_cfg_per_enable;
         per_set_reg <= i_cfg_per_set;
         per_fab_reg <= i_cfg_per_to_fabric;
         gpio_en_reg <= i_cfg_gpio_pads;
         loan_en_reg <= i_cfg_loan_pads;
         permit_reg  <= i_cfg_loan_permit;
         o_cfg_valid <= 1'b1;
      end
   end

   // pad levels toward clocked peripherals and gpio
   pmx_pad_sync #(
      .W (`PMX_NPAD)
   ) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_reset_n (i_reset_n),
      .i_raw     (i_pad_in),
      .o_level   (pad_sync)
   );

   // loaned pad sample follows the pad with no register
   assign o_borrowed_pad_sample_to_fabric = i_pad_in;

   genvar k;
   generate
      for (k = 0; k < `PMX_NPAD; k = k + 1) begin : g_pad
         reg [1:0]              cnt;
         reg [`PMX_IDX_W-1:0]   idx;
         reg [1:0]              own_next;
         reg                    conf_next;
         reg [1:0]              own_reg;
         reg [`PMX_IDX_W-1:0]   idx_reg;
         reg                    conf_reg;
         reg                    out_c;
         reg                    oe_n_c;
         integer                p;
         integer                s;
         integer                t;

         // count peripheral claims on this pad
         always @* begin
            cnt       = `PMX_OWN_NONE;
            idx       = {`PMX_IDX_W{1'b0}};
            own_next  = `PMX_OWN_NONE;
            conf_next = 1'b0;
            t         = 0;
            for (p = 0; p < `PMX_NPER; p = p + 1) begin
               for (s = 0; s < `PMX_PSIG; s = s + 1) begin
                  if (per_en_reg[p] && !per_fab_reg[p] &&
                      pad_of(p, s, per_set_reg[p]) == k) begin
                     if (cnt != `PMX_CNT_MANY) begin
                        cnt = cnt + `PMX_CNT_ONE;
                     end
                     t   = p * `PMX_PSIG + s;
                     idx = t[`PMX_IDX_W-1:0];
                  end
               end
            end
            // more than one owner is a conflict, never driven
            if (cnt == `PMX_CNT_MANY ||
                (cnt == `PMX_CNT_ONE && (gpio_en_reg[k] || loan_en_reg[k])) ||
                (gpio_en_reg[k] && loan_en_reg[k])) begin
               conf_next = 1'b1;
            end else if (cnt == `PMX_CNT_ONE) begin
               own_next = `PMX_OWN_PER;
            end else if (gpio_en_reg[k]) begin
               own_next = `PMX_OWN_GPIO;
            end else if (loan_en_reg[k] && permit_reg) begin
               own_next = `PMX_OWN_LOAN;
            end
         end

         always @(posedge i_sys_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               own_reg  <= `PMX_OWN_NONE;
               idx_reg  <= {`PMX_IDX_W{1'b0}};
               conf_reg <= 1'b0;
            end else begin
               own_reg  <= own_next;
               idx_reg  <= idx;
               conf_reg <= conf_next;
            end
         end

         // pad drive; loaned pad uses element k of the fabric arrays
         always @* begin
            case (own_reg)
               `PMX_OWN_PER: begin
                  out_c  = i_per_out[idx_reg];
                  oe_n_c = ~i_per_oe[idx_reg];
               end
               `PMX_OWN_GPIO: begin
                  out_c  = i_gpio_out[k];
                  oe_n_c = ~i_gpio_oe[k];
               end
               `PMX_OWN_LOAN: begin
                  out_c  = i_borrowed_pad_drive_value[k];
                  oe_n_c = ~i_borrowed_pad_drive_enable[k];
               end
               default: begin
                  out_c  = 1'b0;
                  oe_n_c = 1'b1;
               end
            endcase
         end

         assign o_pad_out[k]     = out_c;
         assign o_pad_oe_n[k]    = oe_n_c;
         assign o_conflict[k]    = conf_reg;
         assign conflict_next[k] = conf_next;
      end
   endgenerate

   // gpio input, passed on every gpio-enabled pad, conflicting ones included
   integer g;
   reg [`PMX_NPAD-1:0] gpio_in_next;
   always @* begin
      gpio_in_next = {`PMX_NPAD{1'b0}};
      for (g = 0; g < `PMX_NPAD; g = g + 1) begin
         if (gpio_en_reg[g]) begin
            gpio_in_next[g] = pad_sync[g];
         end
      end
   end

   // peripheral inputs from pad set or fabric
   integer q;
   integer r;
   integer j;
   reg [`PMX_NPSIG-1:0] per_in_next;
   reg [`PMX_NPSIG-1:0] fab_out_next;
   reg [`PMX_NPSIG-1:0] fab_oe_next;
   always @* begin
      per_in_next  = {`PMX_NPSIG{1'b0}};
      fab_out_next = {`PMX_NPSIG{1'b0}};
      fab_oe_next  = {`PMX_NPSIG{1'b0}};
      j            = 0;
      for (q = 0; q < `PMX_NPER; q = q + 1) begin
         for (r = 0; r < `PMX_PSIG; r = r + 1) begin
            j = q * `PMX_PSIG + r;
            if (per_en_reg[q] && per_fab_reg[q]) begin
               per_in_next[j]  = i_fab_per_in[j];
               fab_out_next[j] = i_per_out[j];
               fab_oe_next[j]  = i_per_oe[j];
            end else if (per_en_reg[q]) begin
               per_in_next[j] = pad_sync[pad_of(q, r, per_set_reg[q])];
            end
         end
      end
   end

   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_per_in       <= {`PMX_NPSIG{1'b0}};
         o_gpio_in      <= {`PMX_NPAD{1'b0}};
         o_fab_per_out  <= {`PMX_NPSIG{1'b0}};
         o_fab_per_oe   <= {`PMX_NPSIG{1'b0}};
         o_conflict_any <= 1'b0;
      end else begin
         o_per_in       <= per_in_next;
         o_gpio_in      <= gpio_in_next;
         o_fab_per_out  <= fab_out_next;
         o_fab_per_oe   <= fab_oe_next;
         o_conflict_any <= |conflict_next;
      end
   end

endmodule // pmx_pad_mux

// >>> test/pmx_pad_mux_monitor.sv
// assertion checker for the pad multiplexer
`timescale 1ns/100ps
module pmx_pad_mux_mon (
   // clock and reset
   input wire        i_sys_clk,
   input wire        i_reset_n,
   // configuration and peripheral side
   input wire        i_cfg_load,
   input wire [3:0]  i_cfg_per_enable,
   input wire [3:0]  i_cfg_per_to_fabric,
   input wire [7:0]  i_per_out,
   // watched outputs and pads
   input wire [7:0]  o_fab_per_out,
   input wire [15:0] o_borrowed_pad_sample_to_fabric,
   input wire [15:0] i_pad_in,
   input wire [15:0] o_pad_oe_n,
   input wire [15:0] o_conflict,
   input wire        o_conflict_any,
   input wire        o_cfg_valid
);
   reg  [3:0] fab_reg;
   reg  [3:0] fab_dly_reg;
   wire [7:0] fab_mask;
   assign fab_mask = {{2{fab_dly_reg[3]}}, {2{fab_dly_reg[2]}},
                      {2{fab_dly_reg[1]}}, {2{fab_dly_reg[0]}}};
   // mirror of the fabric route selection, one edge behind the design
   always @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         fab_reg <= 4'h0;
         fab_dly_reg <= 4'h0;
      end else begin
         fab_reg <= i_cfg_load ? (i_cfg_per_enable & i_cfg_per_to_fabric) : fab_reg;
         fab_dly_reg <= fab_reg;
      end
   end
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   property p_valid_set; i_cfg_load |=> o_cfg_valid; endproperty
   a_valid_set: assert property (p_valid_set) else $error("valid not set");
   property p_valid_hold; o_cfg_valid |=> o_cfg_valid; endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");
   property p_idle_free; !o_cfg_valid |-> (&o_pad_oe_n); endproperty
   a_idle_free: assert property (p_idle_free) else $error("pad driven early");
   property p_sample; o_borrowed_pad_sample_to_fabric == i_pad_in; endproperty
   a_sample: assert property (p_sample) else $error("sample off pad");
   property p_conf_free; (o_conflict & ~o_pad_oe_n) == 16'h0000; endproperty
   a_conf_free: assert property (p_conf_free) else $error("conflict pad driven");
   property p_conf_any; $rose(o_conflict_any) |=> (|o_conflict); endproperty
   a_conf_any: assert property (p_conf_any) else $error("conflict flag lost");
   property p_conf_chg; $changed(o_conflict) |-> $past(i_cfg_load, 2); endproperty
   a_conf_chg: assert property (p_conf_chg) else $error("conflict moved");
   property p_fab; o_fab_per_out == ($past(i_per_out) & fab_mask); endproperty
   a_fab: assert property (p_fab) else $error("fabric route wrong");
   c_conf: cover property ($rose(o_conflict_any));
   c_fab: cover property (o_fab_per_out != 8'h00);
   c_valid: cover property ($rose(o_cfg_valid));
endmodule // pmx_pad_mux_mon
bind pmx_pad_mux pmx_pad_mux_mon i_mon (
   .i_sys_clk                       (i_sys_clk),
   .i_reset_n                       (i_reset_n),
   .i_cfg_load                      (i_cfg_load),
   .i_cfg_per_enable                (i_cfg_per_enable),
   .i_cfg_per_to_fabric             (i_cfg_per_to_fabric),
   .i_per_out                       (i_per_out),
   .o_fab_per_out                   (o_fab_per_out),
   .o_borrowed_pad_sample_to_fabric (o_borrowed_pad_sample_to_fabric),
   .i_pad_in                        (i_pad_in),
   .o_pad_oe_n                      (o_pad_oe_n),
   .o_conflict                      (o_conflict),
   .o_conflict_any                  (o_conflict_any),
   .o_cfg_valid                     (o_cfg_valid)
);

// >>> test/pmx_fab_user.sv
// fabric user logic driving one borrowed pad
`timescale 1ns/100ps
module pmx_fab_user (
   // clock
   input  wire        i_sys_clk,
   // chosen pad and its drive
   input  wire [3:0]  i_sel,
   input  wire        i_val,
   input  wire        i_en,
   // borrowed pad arrays
   input  wire [15:0] i_sample,
   output reg  [15:0] o_drive_value,
   output reg  [15:0] o_drive_enable,
   output wire        o_seen
);
   reg [15:0] noise_reg = 16'h5a5a;
   // unused drive value elements carry a changing pattern, unused enables stay low
   always @(posedge i_sys_clk) noise_reg <= ~noise_reg;
   always @* begin
      o_drive_value = noise_reg;
      o_drive_value[i_sel] = i_val;
      o_drive_enable = 16'h0000;
      o_drive_enable[i_sel] = i_en;
   end
   assign o_seen = i_sample[i_sel];
endmodule // pmx_fab_user

// >>> test/pmx_pad_mux_test.sv
// self-checking bench for the pad multiplexer
`timescale 1ns/100ps
module pmx_pad_mux_test;
   reg         clk = 1'b0, rst_n = 1'b0, load = 1'b0, perm = 1'b0, val = 1'b0, len = 1'b0;
   reg  [3:0]  en = 4'h0, set = 4'h0, fab = 4'h0, sel = 4'h8;
   reg  [15:0] gpio = 16'h0000, loan = 16'h0000, gout = 16'h0000, goe = 16'h0000;
   reg  [15:0] ext = 16'h0000;
   reg  [7:0]  pout = 8'h00, poe = 8'hff, fin = 8'h00;
   reg  [31:0] seed = 32'hc41c_2b95;
   reg  [31:0] rv;
   reg  [34:0] n;
   reg  [34:0] q [$];
   wire [15:0] pad_out, oe_n, smp, conf, gin, dval, den, pad;
   wire [7:0]  pin, fout, foe;
   wire        cany, cvalid, seen;
   wire [127:0] all_o = {5'h00, seen, cvalid, cany, foe, 8'h00, fout, 8'h00, pin,
                         gin, conf, smp, oe_n, pad_out};
   string      nm [0:7] = '{"pad_out", "oe_n", "sample", "conflict", "gpio_in", "per_in",
                            "fab_out", "flags"};
   integer     errors = 0, cmp_count = 0, p, b;
   event       chk;
   assign pad = (~oe_n & pad_out) | (oe_n & ext);
   always #50 clk = ~clk;
   pmx_pad_mux i_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_cfg_load(load),
      .i_cfg_per_enable(en), .i_cfg_per_set(set), .i_cfg_per_to_fabric(fab),
      .i_cfg_gpio_pads(gpio), .i_cfg_loan_pads(loan), .i_cfg_loan_permit(perm),
      .i_per_out(pout), .i_per_oe(poe), .o_per_in(pin), .i_gpio_out(gout),
      .i_gpio_oe(goe), .o_gpio_in(gin), .i_borrowed_pad_drive_value(dval),
      .i_borrowed_pad_drive_enable(den), .o_borrowed_pad_sample_to_fabric(smp),
      .o_fab_per_out(fout), .o_fab_per_oe(foe), .i_fab_per_in(fin), .i_pad_in(pad),
      .o_pad_out(pad_out), .o_pad_oe_n(oe_n), .o_conflict(conf),
      .o_conflict_any(cany), .o_cfg_valid(cvalid));
   pmx_fab_user i_fab (.i_sys_clk(clk), .i_sel(sel), .i_val(val), .i_en(len),
      .i_sample(smp), .o_drive_value(dval), .o_drive_enable(den), .o_seen(seen));
   function [31:0] rnd;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   task check(input [15:0] seen_v, input [15:0] exp_v, input [2:0] k);
      begin
         cmp_count = cmp_count + 1;
         if (seen_v !== exp_v) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", nm[k], exp_v, seen_v);
         end
      end
   endtask
   task note(input [2:0] k, input [15:0] m, input [15:0] e);
      begin
         q.push_back({k, m, e});
         -> chk;
         // inputs hold while the watcher compares
         #1;
      end
   endtask
   // watcher takes the oldest note and compares it with the outputs
   always @(chk) while (q.size() > 0) begin
      n = q.pop_front();
      check(all_o[n[34:32]*16 +: 16] & n[31:16], n[15:0] & n[31:16], n[34:32]);
   end
   task cfg(input [3:0] e, input [3:0] st, input [3:0] f, input [15:0] g, input pm,
            input [15:0] l);
      begin
         @(negedge clk);
         {en, set, fab, gpio, loan, perm} = {e, st, f, g, l, pm};
         load = 1'b1;
         @(negedge clk);
         load = 1'b0;
         repeat (2) @(negedge clk);
      end
   endtask
   task tally_and_finish;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, errors);
         if (errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #500000 errors = errors + 1;
      tally_and_finish;
   end
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      #1 note(3'h1, 16'hffff, 16'hffff);
      note(3'h7, 16'h0300, 16'h0000);
      for (p = 0; p < 8; p = p + 1) begin
         cfg(4'h1 << p[1:0], {4{p[2]}}, 4'h0, 16'h0000, 1'b0, 16'h0000);
         rv = rnd();
         {poe, pout} = rv[15:0];
         b = 2 * (p % 4) + 2 * p[2];
         #1 note(3'h1, 16'h0003 << b, ~({14'h0000, poe[2*(p%4) +: 2]} << b));
         note(3'h0, 16'h0003 << b, {14'h0000, pout[2*(p%4) +: 2]} << b);
      end
      poe = 8'hff;
      cfg(4'h3, 4'h1, 4'h0, 16'h0000, 1'b0, 16'h0100);
      #1 note(3'h3, 16'hffff, 16'h000c);
      note(3'h1, 16'h000c, 16'h000c);
      note(3'h7, 16'h0300, 16'h0300);
      cfg(4'h5, 4'h0, 4'h4, 16'h0010, 1'b1, 16'h0100);
      {goe, gout} = {16'h0010, 16'h0010};
      #1 note(3'h1, 16'h0011, 16'h0000);
      note(3'h0, 16'h0010, 16'h0010);
      note(3'h3, 16'hffff, 16'h0000);
      note(3'h7, 16'h0100, 16'h0000);
      goe = 16'h0000;
      rv = rnd();
      ext = rv[15:0];
      repeat (5) @(posedge clk);
      #1 note(3'h4, 16'hffff, ext & 16'h0010);
      @(negedge clk);
      {len, val} = {1'b1, ~ext[8]};
      #1 note(3'h1, 16'h0100, 16'h0000);
      note(3'h0, 16'h0100, {7'h00, val, 8'h00});
      note(3'h2, 16'h0100, {7'h00, val, 8'h00});
      note(3'h7, 16'h0400, {5'h00, val, 10'h000});
      len = 1'b0;
      #1 note(3'h1, 16'h0100, 16'h0100);
      note(3'h2, 16'hfffc, ext);
      @(negedge clk);
      rv = rnd();
      {pout, fin} = rv[15:0];
      @(posedge clk);
      #1 note(3'h6, 16'h0030, {8'h00, pout});
      note(3'h5, 16'h0030, {8'h00, fin});
      note(3'h7, 16'h0030, 16'h0030);
      cfg(4'h5, 4'h0, 4'h4, 16'h0010, 1'b0, 16'h0100);
      len = 1'b1;
      #1 note(3'h1, 16'h0100, 16'h0100);
      #1 tally_and_finish;
   end
endmodule // pmx_pad_mux_test
